// >>> shared/pmx_cfg.svh
// Purpose: Command codes, field positions and reset values of the monitor slice.
// Assumes: Included by bare name from the bench and the design files.
// Notes: Definitions only.
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

`define PMX_CMD_AUX_RB   8'hdd
`define PMX_CMD_OV_LIM   8'hde
`define PMX_CMD_UV_LIM   8'hdf
`define PMX_CMD_CUR_MIN  8'he3
`define PMX_CMD_PWR_MIN  8'he4
`define PMX_CMD_REV_EN   8'he5
`define PMX_CMD_HYST_LO  8'hf2

`define PMX_AUX_W        12
`define PMX_OV_RST       12'hfff
`define PMX_UV_RST       12'h000
`define PMX_CUR_MIN_RST  16'h07ff
`define PMX_PWR_MIN_RST  16'h7fff
`define PMX_HYST_LO_RST  16'h8000
`define PMX_SIGNED_MAX   24'h7fffff

`define PMX_ACC_LSB      0
`define PMX_WRAP_LSB     24
`define PMX_SAMP_LSB     40

// Arbitrary seven-bit bus address.
`define PMX_DEV_ADDR     7'h10
`define PMX_WR_BYTES     4'h3

`endif

// >>> shared/pmx_pkg.sv
// Purpose: Types shared by the link engine and the register bank.
// Assumes: Widths are written as literals; no constants are taken from pmx_cfg.svh.
// Notes: None.
package pmx_pkg;

	typedef struct packed {
		logic        wr;
		logic [7:0]  cmd;
		logic [15:0] wdata;
	} pmx_req_s;

	typedef struct packed {
		logic [11:0] aux;
		logic [15:0] current;
		logic [15:0] power;
		logic [15:0] hyst;
	} pmx_sample_s;

	typedef enum logic [2:0] {
		LK_IDLE,
		LK_IN,
		LK_ACK,
		LK_HOLD,
		LK_OUT,
		LK_MACK
	} pmx_link_e;

endpackage

// >>> test/pmx_host.sv
// Purpose: Two-wire bus master model issuing command writes and reads.
// Assumes: SCL is driven only by this model; SDA is a pulled-up wire resolved outside.
// Notes: One bit takes four steps of Q ns, so the bus clock period is 4*Q.
`timescale 1ns/100ps
`default_nettype none
module pmx_host #(
	parameter int Q = 600
) (
	// Bus lines
	output logic      o_scl,
	output logic      o_sda_oe,
	input  wire logic i_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end

	// Data changes while SCL is low and is sampled in the middle of the high phase.
	task automatic bit_io(input logic b, output logic r);
		o_sda_oe = ~b;
		#Q o_scl = 1'b1;
		#Q r = i_sda;
		#Q o_scl = 1'b0;
		#Q;
	endtask

	task automatic byte_io(input logic [7:0] w, input logic last, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(w[i], r[i]);
		end
		bit_io(last, a);
		ack = ~a;
	endtask

	task automatic start();
		o_scl = 1'b0;
		o_sda_oe = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda_oe = 1'b1;
		#Q o_scl = 1'b0;
		#Q;
	endtask

	task automatic stop();
		o_sda_oe = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_oe = 1'b0;
		#Q;
	endtask

	task automatic wr(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] d, input int nd,
			output logic ok);
		logic [7:0] r;
		logic a;
		start();
		byte_io({adr, 1'b0}, 1'b1, r, ok);
		byte_io(cmd, 1'b1, r, a);
		for (int k = 0; k < nd; k++) begin
			byte_io(d[8*k +: 8], 1'b1, r, a);
		end
		stop();
	endtask

	// All bytes of a readout are taken in one frame so that they belong together.
	task automatic rd(input logic [6:0] adr, input logic [7:0] cmd, input int n, output logic [63:0] v);
		logic [7:0] r;
		logic a;
		v = '0;
		start();
		byte_io({adr, 1'b0}, 1'b1, r, a);
		byte_io(cmd, 1'b1, r, a);
		start();
		byte_io({adr, 1'b1}, 1'b1, r, a);
		for (int k = 0; k < n; k++) begin
			byte_io(8'hff, k == n - 1, r, a);
			v[8*k +: 8] = r;
		end
		stop();
	endtask
endmodule
`default_nettype wire

// >>> test/pmx_regs_bench.sv
// Purpose: Self-checking bench for the monitor register slice, both variants.
// Assumes: Host model on the shared bus; inputs change at the falling clock edge.
// Notes: The signed variant sits at another address on the same bus.
`timescale 1ns/100ps
`default_nettype none
`include "pmx_cfg.svh"
module pmx_regs_bench;
	localparam logic [6:0] ADDR_S = 7'h12;
	localparam int         LIMIT  = 90000;
	logic                  clk, rst, link_clk, link_rst, scl, host_oe, oe_u, oe_s, sda_out;
	logic                  sample_valid, e_valid, e_rev, ov, uv, flag, ok;
	logic [23:0]           e_inc, count;
	logic [63:0]           v;
	pmx_pkg::pmx_sample_s  sample;
	wire logic             sda;
	int                    errors, checks, cycles;
	logic [7:0]            cmds [6] = '{8'hdd, 8'hde, 8'hdf, 8'he3, 8'he4, 8'hf2};
	logic [15:0]           rstv [6] = '{16'h0000, 16'h0fff, 16'h0000, 16'h07ff, 16'h7fff, 16'h8000};

	assign sda = ~(host_oe | oe_u | oe_s);

	pmx_host u_pmx_host (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));

	pmx_regs #(.SIGNED_VARIANT(1'b0)) u_pmx_regs (
		.i_clk(clk), .i_rst(rst), .i_link_clk(link_clk), .i_link_rst(link_rst),
		.i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe_u),
		.i_sample_valid(sample_valid), .i_sample(sample),
		.i_energy_valid(e_valid), .i_energy_reverse(e_rev), .i_energy_inc(e_inc),
		.o_aux_ov_warn(ov), .o_aux_uv_warn(uv), .o_below_lower_flag(flag), .o_sample_count(count));

	pmx_regs #(.DEV_ADDR(ADDR_S), .SIGNED_VARIANT(1'b1)) u_pmx_regs_signed (
		.i_clk(clk), .i_rst(rst), .i_link_clk(link_clk), .i_link_rst(link_rst),
		.i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(oe_s),
		.i_sample_valid(sample_valid), .i_sample(sample),
		.i_energy_valid(e_valid), .i_energy_reverse(e_rev), .i_energy_inc(e_inc),
		.o_aux_ov_warn(), .o_aux_uv_warn(), .o_below_lower_flag(), .o_sample_count());

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	task automatic summarize();
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			summarize();
		end
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rw(input logic [7:0] cmd, input logic [63:0] exp);
		u_pmx_host.rd(`PMX_DEV_ADDR, cmd, 2, v);
		chk($sformatf("command %h", cmd), exp, v);
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		u_pmx_host.wr(`PMX_DEV_ADDR, cmd, d, 2, ok);
	endtask

	task automatic samp(input logic [11:0] aux, input logic [15:0] cur, input logic [15:0] pwr,
			input logic [15:0] hy);
		@(negedge clk);
		sample_valid = 1'b1;
		sample = {aux, cur, pwr, hy};
		@(negedge clk);
		sample_valid = 1'b0;
		@(negedge clk);
	endtask

	task automatic nrg(input logic rev, input logic [23:0] inc);
		@(negedge clk);
		e_valid = 1'b1;
		e_rev = rev;
		e_inc = inc;
		@(negedge clk);
		e_valid = 1'b0;
	endtask

	initial begin
		rst = 1'b1;
		link_rst = 1'b1;
		sample_valid = 1'b0;
		sample = '0;
		e_valid = 1'b0;
		e_rev = 1'b0;
		e_inc = '0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		@(posedge link_clk);
		link_rst <= 1'b0;
		@(negedge clk);
		chk("count after reset", 64'h0, 64'(count));
		chk("data drive level", 64'h0, 64'(sda_out));
		for (int k = 0; k < 6; k++) begin
			rw(cmds[k], 64'(rstv[k]));
		end
		wr(`PMX_CMD_OV_LIM, 16'hf123);
		chk("address ack", 64'h1, 64'(ok));
		wr(`PMX_CMD_UV_LIM, 16'h0100);
		wr(`PMX_CMD_HYST_LO, 16'h1234);
		u_pmx_host.wr(`PMX_DEV_ADDR, `PMX_CMD_HYST_LO, 16'h0055, 1, ok);
		wr(`PMX_CMD_AUX_RB, 16'h0abc);
		u_pmx_host.wr(7'h33, `PMX_CMD_OV_LIM, 16'h0001, 2, ok);
		chk("foreign address ack", 64'h0, 64'(ok));
		rw(`PMX_CMD_OV_LIM, 64'h0123);
		rw(`PMX_CMD_UV_LIM, 64'h0100);
		rw(`PMX_CMD_HYST_LO, 64'h1234);
		rw(`PMX_CMD_AUX_RB, 64'h0000);
		rw(8'ha0, 64'h0000);
		samp(12'h200, 16'h0010, 16'hfff0, 16'h1000);
		chk("overvoltage warn", 64'h1, 64'(ov));
		chk("undervoltage warn", 64'h0, 64'(uv));
		chk("below lower flag", 64'h1, 64'(flag));
		samp(12'h050, 16'h0020, 16'h0000, 16'h1234);
		chk("overvoltage warn", 64'h0, 64'(ov));
		chk("undervoltage warn", 64'h1, 64'(uv));
		chk("below lower flag", 64'h0, 64'(flag));
		rw(`PMX_CMD_AUX_RB, 64'h0050);
		rw(`PMX_CMD_CUR_MIN, 64'h0010);
		rw(`PMX_CMD_PWR_MIN, 64'hfff0);
		wr(`PMX_CMD_UV_LIM, 16'h0000);
		samp(12'h000, 16'h0400, 16'h0100, 16'h1234);
		chk("undervoltage warn disabled", 64'h0, 64'(uv));
		wr(`PMX_CMD_CUR_MIN, 16'h0005);
		rw(`PMX_CMD_CUR_MIN, 64'h0010);
		wr(`PMX_CMD_CUR_MIN, 16'h0000);
		wr(`PMX_CMD_PWR_MIN, 16'h0000);
		rw(`PMX_CMD_CUR_MIN, 64'h07ff);
		rw(`PMX_CMD_PWR_MIN, 64'h7fff);
		nrg(1'b1, 24'h7ffff0);
		nrg(1'b1, 24'h000020);
		nrg(1'b0, 24'h000005);
		nrg(1'b1, 24'h7ffff0);
		nrg(1'b1, 24'h000003);
		@(negedge clk);
		chk("sample count", 64'h5, 64'(count));
		u_pmx_host.rd(`PMX_DEV_ADDR, `PMX_CMD_REV_EN, 8, v);
		chk("reverse readout", {24'h000005, 16'h0001, 24'h000003}, v);
		u_pmx_host.rd(ADDR_S, `PMX_CMD_REV_EN, 8, v);
		chk("signed reverse readout", {24'h000005, 16'h0002, 24'h000003}, v);
		summarize();
	end
endmodule
`default_nettype wire

// >>> verilog/pmx_link.sv
// Purpose: Two-wire slave engine on the link clock; turns frames into requests.
// Assumes: Link clock runs free and oversamples the bus lines.
// Notes: Words are sent and taken low byte first.
`timescale 1ns/100ps
`default_nettype none
`include "pmx_cfg.svh"
module pmx_link #(
	parameter logic [6:0]    DEV_ADDR = `PMX_DEV_ADDR
) (
	// Link clock and reset
	input  wire logic        i_link_clk,
	input  wire logic        i_link_rst,
	// Bus lines
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_oe,
	// Request handshake to the register domain
	output logic             o_req_tgl,
	output pmx_pkg::pmx_req_s o_req,
	input  wire logic        i_ack_tgl,
	input  wire logic [63:0] i_rdata
);
	logic [2:0] scl_q, sda_q, ack_q;
	pmx_pkg::pmx_link_e st_q;
	logic [7:0]  sh_q, cmd_q;
	logic [15:0] wd_q;
	logic [63:0] rdat_q;
	logic [2:0]  bits_q, idx_q;
	logic [3:0]  nb_q;
	logic        first_q, rd_q, ackit_q;
	logic        scl_rise, scl_fall, start, stop, pending;
	logic [7:0]  b;

	always_ff @(posedge i_link_clk) begin
		if (i_link_rst) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			ack_q <= 3'h0;
		end else begin
			scl_q <= {scl_q[1:0], i_scl};
			sda_q <= {sda_q[1:0], i_sda};
			ack_q <= {ack_q[1:0], i_ack_tgl};
		end
	end

	always_comb begin
		scl_rise = scl_q[1] & ~scl_q[2];
		scl_fall = ~scl_q[1] & scl_q[2];
		start    = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
		stop     = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
		pending  = o_req_tgl != ack_q[1];
		b        = {sh_q[6:0], sda_q[1]};
	end

	// The read snapshot of one command is kept for the whole frame.
	always_ff @(posedge i_link_clk) begin
		if (i_link_rst) begin
			rdat_q <= 64'h0;
		end else if (ack_q[1] != ack_q[2]) begin
			rdat_q <= i_rdata;
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (i_link_rst) begin
			st_q <= pmx_pkg::LK_IDLE;
			o_sda_oe <= 1'b0;
			o_req_tgl <= 1'b0;
			o_req <= '0;
			sh_q <= 8'h0;
			cmd_q <= 8'h0;
			wd_q <= 16'h0;
			bits_q <= 3'h0;
			idx_q <= 3'h0;
			nb_q <= 4'h0;
			first_q <= 1'b0;
			rd_q <= 1'b0;
			ackit_q <= 1'b0;
		end else if (start) begin
			st_q <= pmx_pkg::LK_IN;
			o_sda_oe <= 1'b0;
			bits_q <= 3'h0;
			nb_q <= 4'h0;
			first_q <= 1'b1;
		end else if (stop) begin
			st_q <= pmx_pkg::LK_IDLE;
			o_sda_oe <= 1'b0;
			if (!rd_q && nb_q >= `PMX_WR_BYTES && !pending) begin
				o_req <= '{wr: 1'b1, cmd: cmd_q, wdata: wd_q};
				o_req_tgl <= ~o_req_tgl;
			end
		end else begin
			unique case (st_q)
				pmx_pkg::LK_IDLE: begin
				end
				pmx_pkg::LK_IN: if (scl_rise) begin
					sh_q <= b;
					bits_q <= bits_q + 3'h1;
					if (bits_q == 3'h7) begin
						st_q <= pmx_pkg::LK_ACK;
						if (first_q) begin
							ackit_q <= b[7:1] == DEV_ADDR;
							rd_q <= b[0];
							first_q <= 1'b0;
							idx_q <= 3'h0;
						end else begin
							ackit_q <= 1'b1;
							if (nb_q != 4'hf) begin
								nb_q <= nb_q + 4'h1;
							end
							if (nb_q == 4'h0) begin
								cmd_q <= b;
								if (!pending) begin
									o_req <= '{wr: 1'b0, cmd: b, wdata: 16'h0};
									o_req_tgl <= ~o_req_tgl;
								end
							end else if (nb_q == 4'h1) begin
								wd_q[7:0] <= b;
							end else if (nb_q == 4'h2) begin
								wd_q[15:8] <= b;
							end
						end
					end
				end
				pmx_pkg::LK_ACK: if (scl_fall) begin
					o_sda_oe <= ackit_q;
					st_q <= ackit_q ? pmx_pkg::LK_HOLD : pmx_pkg::LK_IDLE;
				end
				pmx_pkg::LK_HOLD: if (scl_fall) begin
					bits_q <= 3'h0;
					if (rd_q) begin
						sh_q <= rdat_q[{idx_q, 3'h0} +: 8];
						o_sda_oe <= ~rdat_q[{idx_q, 3'h7}];
						st_q <= pmx_pkg::LK_OUT;
					end else begin
						o_sda_oe <= 1'b0;
						st_q <= pmx_pkg::LK_IN;
					end
				end
				pmx_pkg::LK_OUT: if (scl_fall) begin
					bits_q <= bits_q + 3'h1;
					if (bits_q == 3'h7) begin
						o_sda_oe <= 1'b0;
						st_q <= pmx_pkg::LK_MACK;
					end else begin
						sh_q <= {sh_q[6:0], 1'b0};
						o_sda_oe <= ~sh_q[6];
					end
				end
				pmx_pkg::LK_MACK: if (scl_rise) begin
					if (sda_q[1]) begin
						st_q <= pmx_pkg::LK_IDLE;
					end else begin
						idx_q <= idx_q + 3'h1;
						st_q <= pmx_pkg::LK_HOLD;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> verilog/pmx_min_peak.sv
// Purpose: Tracks the most negative signed value seen since reset or clear.
// Assumes: Sample and clear are one-cycle pulses on i_clk.
// Notes: A sample in the clearing cycle is kept against the default.
`timescale 1ns/100ps
`default_nettype none
module pmx_min_peak #(
	parameter int              W         = 16,
	parameter logic [W-1:0]    RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// Events
	input  wire logic          i_sample_valid,
	input  wire logic [W-1:0]  i_value,
	input  wire logic          i_clear,
	// State
	output logic      [W-1:0]  o_min
);
	logic [W-1:0] base;

	always_comb begin
		base = i_clear ? RESET_VAL : o_min;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_min <= RESET_VAL;
		end else if (i_sample_valid && ($signed(i_value) < $signed(base))) begin
			o_min <= i_value;
		end else begin
			o_min <= base;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/pmx_regs.sv
// Purpose: Auxiliary limits, minimum peaks, reverse energy readout and lower
//          hysteresis threshold of a power monitor, reached over a two-wire bus.
// Assumes: Samples arrive as one-cycle pulses on i_clk; the bus engine runs on
//          the free link clock and crosses by a toggle handshake.
// Notes: The design-side rules follow.
`timescale 1ns/100ps
`default_nettype none
`include "pmx_cfg.svh"
module pmx_regs #(
	parameter logic [6:0]    DEV_ADDR       = `PMX_DEV_ADDR,
	parameter bit            SIGNED_VARIANT = 1'b0
) (
	// System clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Link clock and reset
	input  wire logic        i_link_clk,
	input  wire logic        i_link_rst,
	// Bus lines
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	// Averaged samples
	input  wire logic        i_sample_valid,
	input  wire pmx_pkg::pmx_sample_s i_sample,
	// Energy accumulation
	input  wire logic        i_energy_valid,
	input  wire logic        i_energy_reverse,
	input  wire logic [23:0] i_energy_inc,
	// Status
	output logic             o_aux_ov_warn,
	output logic             o_aux_uv_warn,
	output logic             o_below_lower_flag,
	output logic [23:0]      o_sample_count
);
	logic              req_tgl, ack_q;
	pmx_pkg::pmx_req_s req;
	logic [2:0]        rq_q;
	logic              evt, wr_evt;
	logic [63:0]       rdata_q;
	logic [11:0]       aux_q, ov_lim_q, uv_lim_q;
	logic [15:0]       hyst_lo_q, cur_min, pwr_min;
	logic [23:0]       acc_q, acc_d;
	logic [15:0]       wrap_q;
	logic              wrap_ev;
	logic              clr_cur, clr_pwr;

	pmx_link #(
		.DEV_ADDR   (DEV_ADDR)
	) u_link (
		.i_link_clk (i_link_clk),
		.i_link_rst (i_link_rst),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.o_sda_oe   (o_sda_oe),
		.o_req_tgl  (req_tgl),
		.o_req      (req),
		.i_ack_tgl  (ack_q),
		.i_rdata    (rdata_q)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sda_out <= 1'b0;
		end else begin
			o_sda_out <= 1'b0;
		end
	end

	// Request toggle synchroniser; the request word is held stable until answered.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rq_q <= 3'h0;
		end else begin
			rq_q <= {rq_q[1:0], req_tgl};
		end
	end

	always_comb begin
		evt    = rq_q[1] ^ rq_q[2];
		wr_evt = evt && req.wr;
	end

	function automatic logic hit(input logic [7:0] cmd, input logic [7:0] code);
		hit = cmd == code;
	endfunction

	function automatic logic [63:0] read_mux(input logic [7:0] cmd);
		read_mux = 64'h0;
		if (hit(cmd, `PMX_CMD_AUX_RB)) begin
			read_mux = {52'h0, aux_q};
		end else if (hit(cmd, `PMX_CMD_OV_LIM)) begin
			read_mux = {52'h0, ov_lim_q};
		end else if (hit(cmd, `PMX_CMD_UV_LIM)) begin
			read_mux = {52'h0, uv_lim_q};
		end else if (hit(cmd, `PMX_CMD_CUR_MIN)) begin
			read_mux = {48'h0, cur_min};
		end else if (hit(cmd, `PMX_CMD_PWR_MIN)) begin
			read_mux = {48'h0, pwr_min};
		end else if (hit(cmd, `PMX_CMD_REV_EN)) begin
			read_mux = {o_sample_count, wrap_q, acc_q};
		end else if (hit(cmd, `PMX_CMD_HYST_LO)) begin
			read_mux = {48'h0, hyst_lo_q};
		end
	endfunction

	// One snapshot per command byte keeps all eight readout bytes coherent.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_q <= 64'h0;
			ack_q <= 1'b0;
		end else if (evt) begin
			ack_q <= ~ack_q;
			if (!req.wr) begin
				rdata_q <= read_mux(req.cmd);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ov_lim_q <= `PMX_OV_RST;
			uv_lim_q <= `PMX_UV_RST;
			hyst_lo_q <= `PMX_HYST_LO_RST;
		end else if (wr_evt) begin
			if (hit(req.cmd, `PMX_CMD_OV_LIM)) begin
				ov_lim_q <= req.wdata[11:0];
			end
			if (hit(req.cmd, `PMX_CMD_UV_LIM)) begin
				uv_lim_q <= req.wdata[11:0];
			end
			if (hit(req.cmd, `PMX_CMD_HYST_LO)) begin
				hyst_lo_q <= req.wdata;
			end
		end
	end

	always_comb begin
		clr_cur = wr_evt && hit(req.cmd, `PMX_CMD_CUR_MIN) && req.wdata == 16'h0;
		clr_pwr = wr_evt && hit(req.cmd, `PMX_CMD_PWR_MIN) && req.wdata == 16'h0;
	end

	pmx_min_peak #(
		.W              (16),
		.RESET_VAL      (`PMX_CUR_MIN_RST)
	) u_cur_min (
		.i_clk          (i_clk),
		.i_rst          (i_rst),
		.i_sample_valid (i_sample_valid),
		.i_value        (i_sample.current),
		.i_clear        (clr_cur),
		.o_min          (cur_min)
	);

	pmx_min_peak #(
		.W              (16),
		.RESET_VAL      (`PMX_PWR_MIN_RST)
	) u_pwr_min (
		.i_clk          (i_clk),
		.i_rst          (i_rst),
		.i_sample_valid (i_sample_valid),
		.i_value        (i_sample.power),
		.i_clear        (clr_pwr),
		.o_min          (pwr_min)
	);

	// Limit checks and the lower comparison follow each averaged sample.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			aux_q <= 12'h0;
			o_aux_ov_warn <= 1'b0;
			o_aux_uv_warn <= 1'b0;
			o_below_lower_flag <= 1'b0;
		end else if (i_sample_valid) begin
			aux_q <= i_sample.aux;
			o_aux_ov_warn <= ov_lim_q != `PMX_OV_RST && i_sample.aux > ov_lim_q;
			o_aux_uv_warn <= uv_lim_q != `PMX_UV_RST && i_sample.aux < uv_lim_q;
			o_below_lower_flag <= $signed(i_sample.hyst) < $signed(hyst_lo_q);
		end
	end

	always_comb begin
		if (SIGNED_VARIANT) begin
			acc_d = {1'b0, acc_q[22:0]} + {1'b0, i_energy_inc[22:0]};
			wrap_ev = acc_d[23];
			acc_d[23] = 1'b0;
		end else begin
			{wrap_ev, acc_d} = {1'b0, acc_q} + {1'b0, i_energy_inc};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sample_count <= 24'h0;
			acc_q <= 24'h0;
			wrap_q <= 16'h0;
		end else if (i_energy_valid) begin
			o_sample_count <= o_sample_count + 24'h1;
			if (i_energy_reverse) begin
				acc_q <= acc_d;
				wrap_q <= wrap_q + 16'(wrap_ev);
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Register writes and readback snapshots.
	a_aux_read_pad: assert property (
		evt && !req.wr && req.cmd == `PMX_CMD_AUX_RB |=> rdata_q == {52'h0, $past(aux_q)})
		else $error("aux readback wrong");
	a_aux_store: assert property (
		i_sample_valid |=> aux_q == $past(i_sample.aux))
		else $error("aux sample not kept");
	a_ov_write: assert property (
		wr_evt && req.cmd == `PMX_CMD_OV_LIM |=> ov_lim_q == $past(req.wdata[11:0]))
		else $error("overvoltage limit not stored");
	a_uv_write: assert property (
		wr_evt && req.cmd == `PMX_CMD_UV_LIM |=> uv_lim_q == $past(req.wdata[11:0]))
		else $error("undervoltage limit not stored");
	a_hyst_write: assert property (
		wr_evt && req.cmd == `PMX_CMD_HYST_LO |=> hyst_lo_q == $past(req.wdata))
		else $error("lower threshold not stored");
	a_readout_order: assert property (
		evt && !req.wr && req.cmd == `PMX_CMD_REV_EN |=> rdata_q[23:0] == $past(acc_q)
		&& rdata_q[39:24] == $past(wrap_q) && rdata_q[63:40] == $past(o_sample_count))
		else $error("readout order wrong");

	// Warning limits and the lower comparison.
	a_ov_disable: assert property (
		i_sample_valid && ov_lim_q == `PMX_OV_RST |=> !o_aux_ov_warn)
		else $error("ov warn while disabled");
	a_uv_disable: assert property (
		i_sample_valid && uv_lim_q == `PMX_UV_RST |=> !o_aux_uv_warn)
		else $error("uv warn while disabled");
	a_ov_detect: assert property (
		i_sample_valid && ov_lim_q != `PMX_OV_RST && i_sample.aux > ov_lim_q |=> o_aux_ov_warn)
		else $error("ov warn missed");
	a_uv_detect: assert property (
		i_sample_valid && uv_lim_q != `PMX_UV_RST && i_sample.aux < uv_lim_q |=> o_aux_uv_warn)
		else $error("uv warn missed");
	a_below_flag: assert property (
		i_sample_valid |=>
		o_below_lower_flag == ($signed($past(i_sample.hyst)) < $signed($past(hyst_lo_q))))
		else $error("below flag wrong");
	a_flag_hold: assert property (
		!i_sample_valid |=> $stable(o_below_lower_flag))
		else $error("below flag moved without sample");

	// Minimum trackers.
	a_cur_clear: assert property (
		clr_cur && !i_sample_valid |=> cur_min == `PMX_CUR_MIN_RST)
		else $error("current min not restored");
	a_pwr_clear: assert property (
		clr_pwr && !i_sample_valid |=> pwr_min == `PMX_PWR_MIN_RST)
		else $error("power min not restored");
	a_cur_refuse: assert property (
		wr_evt && req.cmd == `PMX_CMD_CUR_MIN && req.wdata != 16'h0 && !i_sample_valid |=> $stable(cur_min))
		else $error("current min took nonzero write");
	a_cur_track: assert property (
		i_sample_valid && !clr_cur && $signed(i_sample.current) < $signed(cur_min)
		|=> cur_min == $past(i_sample.current))
		else $error("current min not lowered");
	a_min_hold: assert property (
		i_sample_valid && !clr_cur && $signed(i_sample.current) >= $signed(cur_min) |=> $stable(cur_min))
		else $error("current min moved up");
	a_pwr_track: assert property (
		i_sample_valid && !clr_pwr && $signed(i_sample.power) < $signed(pwr_min)
		|=> pwr_min == $past(i_sample.power))
		else $error("power min not lowered");
	a_pwr_hold: assert property (
		i_sample_valid && !clr_pwr && $signed(i_sample.power) >= $signed(pwr_min) |=> $stable(pwr_min))
		else $error("power min moved up");

	// Energy accumulation.
	a_wrap_count: assert property (
		i_energy_valid && i_energy_reverse && wrap_ev |=> wrap_q == $past(wrap_q) + 16'h1)
		else $error("wrap not counted");
	a_wrap_hold: assert property (
		!(i_energy_valid && i_energy_reverse && wrap_ev) |=> $stable(wrap_q))
		else $error("wrap counted without wrap");
	a_signed_range: assert property (
		SIGNED_VARIANT && i_energy_valid |=> acc_q <= `PMX_SIGNED_MAX)
		else $error("signed accumulator out of range");
	a_acc_forward: assert property (
		i_energy_valid && !i_energy_reverse |=> $stable(acc_q))
		else $error("forward sample moved reverse accumulator");
	a_sample_total: assert property (
		i_energy_valid |=> o_sample_count == $past(o_sample_count) + 24'h1)
		else $error("sample count slip");
	a_count_idle: assert property (
		!i_energy_valid |=> $stable(o_sample_count))
		else $error("sample count moved without sample");

	c_rev_read: cover property (evt && !req.wr && req.cmd == `PMX_CMD_REV_EN);
	c_wrap: cover property (i_energy_valid && i_energy_reverse && wrap_ev);
	c_cur_clear: cover property (clr_cur);
	c_below: cover property (o_below_lower_flag);
	c_ov_warn: cover property (o_aux_ov_warn);
endmodule
`default_nettype wire
